/* File: include/sdr_pkg.sv */
// Purpose: shared constants and types for the bank interleaving block
// Assumes: commands and data sampled on the rising edge of core_clk
// Notes:   timing figures are in ns and turned into cycle counts here
package sdr_pkg;
    localparam int TCK_NS = 100;
    localparam int TWR_NS = 15;
    localparam int TRP_NS = 20;
    localparam int TWR_RAW = (TWR_NS + TCK_NS - 1) / TCK_NS;
    localparam int TRP_RAW = (TRP_NS + TCK_NS - 1) / TCK_NS;
    localparam int TWR_CYC = (TWR_RAW < 1) ? 1 : TWR_RAW;
    localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;

    localparam int NBANK = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 12;
    localparam int DQ_W = 16;
    localparam int COL_W = 8;
    localparam int LEN_W = 9;
    localparam int CNT_W = 4;

    localparam logic [CNT_W-1:0] TWR_CNT = CNT_W'(TWR_CYC);
    localparam logic [CNT_W-1:0] TRP_CNT = CNT_W'(TRP_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // Command codes as {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_NO_OPERATION = 3'h7;

    localparam int AUTO_PRECHARGE_ADDRESS_BIT = 10;

    // Mode word layout
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_WB_BIT = 9;
    localparam logic [ADDR_W-1:0] MODE_RESET = 12'h020;
    localparam logic [2:0] CL_THREE = 3'h3;

    localparam logic [LEN_W-1:0] LEN_ONE = 9'h001;
    localparam logic [LEN_W-1:0] PAGE_LEN = 9'h100;
    localparam logic [COL_W-1:0] PAGE_MASK = 8'hFF;

    typedef enum logic [2:0] {
        SDR_IDLE = 3'b001,
        SDR_ACT = 3'b010,
        SDR_PRE = 3'b100
    } sdr_bank_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } sdr_cmd_s;

    typedef struct packed {
        logic [BA_W-1:0] ba;
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0] data;
    } sdr_wword_s;

    function automatic logic [LEN_W-1:0] sdr_burst_len(input logic [2:0] c);
        case (c)
            3'h0: sdr_burst_len = 9'h001;
            3'h1: sdr_burst_len = 9'h002;
            3'h2: sdr_burst_len = 9'h004;
            3'h3: sdr_burst_len = 9'h008;
            3'h7: sdr_burst_len = PAGE_LEN;
            default: sdr_burst_len = 9'h001;
        endcase
    endfunction
endpackage

/* File: hdl/sdr_fifo.sv */
// Purpose: write data buffer between the pins and the array
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module sdr_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clk_en) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

/* File: hdl/sdr_bank_ctl.sv */
// Purpose: four-bank access engine with concurrent auto precharge
// Assumes: controller keeps its own timing; commands are synchronous
// Notes:
// Notes on behaviour
// - A READ to another bank cuts a running auto-precharge write burst.
// - Read data appears CAS latency after the READ edge.
// - After a READ cut the old bank precharges once write recovery has run.
// - A write cut by a READ stores last the word taken one clock before it.
// - A WRITE to another bank cuts a running auto-precharge write burst.
// - After a WRITE cut the old bank precharges once write recovery has run.
// - After a WRITE cut the word on the new WRITE edge goes to the new bank.
// - Any command sampled with chip select high is a no-operation command.
// - An auto-precharge access precharges its row once the burst ends.
// - An access to another bank is taken while auto precharge still runs.
`timescale 1ns/1ps
module sdr_bank_ctl #(
    parameter int MEM_COL_W = 4,
    parameter int FIFO_DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Command pins
    input wire sdr_pkg::sdr_cmd_s cmd,
    // Data pins
    input wire logic [sdr_pkg::DQ_W-1:0] dq_in,
    output logic [sdr_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe_n,
    // Status
    output logic wr_ready,
    output logic [sdr_pkg::NBANK-1:0] bank_idle
);
    localparam int NB = sdr_pkg::NBANK;
    localparam int MEM_W = sdr_pkg::BA_W + MEM_COL_W;
    localparam int TWR_D = sdr_pkg::TWR_CYC;
    localparam int TRP_D = sdr_pkg::TRP_CYC;

    // Decode
    logic [2:0] op;
    logic ap_req;
    logic rd_acc;
    logic wr_acc;
    logic new_acc;
    logic all_idle;

    // Mode
    logic [sdr_pkg::ADDR_W-1:0] mode_reg;
    logic [sdr_pkg::ADDR_W-1:0] next_mode_reg;
    logic [sdr_pkg::LEN_W-1:0] bl_len;
    logic [sdr_pkg::LEN_W-1:0] len;
    logic [2:0] cl;

    // Burst engine
    logic bst_on, bst_wr, bst_ap;
    logic [sdr_pkg::BA_W-1:0] bst_bank;
    logic [sdr_pkg::COL_W-1:0] bst_col, bst_mask;
    logic [sdr_pkg::LEN_W-1:0] bst_left;
    logic next_bst_on, next_bst_wr, next_bst_ap;
    logic [sdr_pkg::BA_W-1:0] next_bst_bank;
    logic [sdr_pkg::COL_W-1:0] next_bst_col, next_bst_mask;
    logic [sdr_pkg::LEN_W-1:0] next_bst_left;
    logic stop;
    logic beat_on, beat_wr;
    logic [sdr_pkg::BA_W-1:0] beat_bank;
    logic [sdr_pkg::COL_W-1:0] beat_col;
    logic int_on, int_wr, end_on, end_wr;
    logic [sdr_pkg::BA_W-1:0] int_bank, end_bank;

    // Banks
    sdr_pkg::sdr_bank_e bank_state [NB];
    sdr_pkg::sdr_bank_e next_bank_state [NB];
    logic [sdr_pkg::CNT_W-1:0] wcnt [NB];
    logic [sdr_pkg::CNT_W-1:0] next_wcnt [NB];
    logic [sdr_pkg::CNT_W-1:0] rcnt [NB];
    logic [sdr_pkg::CNT_W-1:0] next_rcnt [NB];
    logic [NB-1:0] ap_pend, next_ap_pend, pre_go;

    // Data path
    sdr_pkg::sdr_wword_s fifo_in, fifo_out;
    logic fifo_in_valid, fifo_out_valid, fifo_out_ready;
    logic [sdr_pkg::DQ_W-1:0] mem [2**MEM_W];
    logic [sdr_pkg::DQ_W-1:0] pipe_d [2];
    logic [sdr_pkg::DQ_W-1:0] next_pipe_d [2];
    logic [1:0] pipe_v, next_pipe_v;
    logic [sdr_pkg::DQ_W-1:0] next_dq_out;
    logic next_dq_oe_n;

    assign op = cmd.cs_n ? sdr_pkg::CMD_NO_OPERATION
        : {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign ap_req = cmd.addr[sdr_pkg::AUTO_PRECHARGE_ADDRESS_BIT];
    // Other banks may still run auto precharge
    assign rd_acc = (op == sdr_pkg::CMD_READ) &&
        (bank_state[cmd.ba] == sdr_pkg::SDR_ACT);
    assign wr_acc = (op == sdr_pkg::CMD_WRITE) &&
        (bank_state[cmd.ba] == sdr_pkg::SDR_ACT);
    assign new_acc = rd_acc || wr_acc;
    assign cl = mode_reg[sdr_pkg::MODE_CL_LSB +: 3];
    assign bl_len =
        sdr_pkg::sdr_burst_len(mode_reg[sdr_pkg::MODE_BL_LSB +: 3]);
    assign len = (wr_acc && mode_reg[sdr_pkg::MODE_WB_BIT])
        ? sdr_pkg::LEN_ONE : bl_len;
    assign stop = (op == sdr_pkg::CMD_BURST_STOP) ||
        ((op == sdr_pkg::CMD_PRECHARGE) && bst_on &&
        (ap_req || cmd.ba == bst_bank));

    always_comb begin
        all_idle = !bst_on;
        for (int b = 0; b < NB; b++) begin
            bank_idle[b] = bank_state[b] == sdr_pkg::SDR_IDLE;
            all_idle = all_idle && bank_idle[b];
        end
    end

    // Mode word taken whenever all banks idle and no burst runs, refresh done or not
    always_comb begin
        next_mode_reg = mode_reg;
        if (op == sdr_pkg::CMD_LOAD_MODE && all_idle) begin
            next_mode_reg = cmd.addr;
        end
    end

    always_comb begin
        next_bst_on = bst_on;
        next_bst_wr = bst_wr;
        next_bst_ap = bst_ap;
        next_bst_bank = bst_bank;
        next_bst_col = bst_col;
        next_bst_mask = bst_mask;
        next_bst_left = bst_left;
        beat_on = 1'b0;
        beat_wr = bst_wr;
        beat_bank = bst_bank;
        beat_col = bst_col;
        int_on = 1'b0;
        int_wr = bst_wr;
        int_bank = bst_bank;
        end_on = 1'b0;
        end_wr = bst_wr;
        end_bank = bst_bank;
        if (new_acc) begin
            // Old burst cut here; its data on this edge is not stored
            int_on = bst_on && bst_ap && (cmd.ba != bst_bank);
            beat_on = 1'b1;
            beat_wr = wr_acc;
            beat_bank = cmd.ba;
            beat_col = cmd.addr[sdr_pkg::COL_W-1:0];
            next_bst_on = len != sdr_pkg::LEN_ONE;
            next_bst_wr = wr_acc;
            next_bst_ap = ap_req;
            next_bst_bank = cmd.ba;
            next_bst_mask = (len == sdr_pkg::PAGE_LEN) ? sdr_pkg::PAGE_MASK
                : sdr_pkg::COL_W'(len - sdr_pkg::LEN_ONE);
            next_bst_col = (beat_col & ~next_bst_mask) |
                ((beat_col + 8'h01) & next_bst_mask);
            next_bst_left = len - sdr_pkg::LEN_ONE;
            end_on = ap_req && (len == sdr_pkg::LEN_ONE);
            end_wr = wr_acc;
            end_bank = cmd.ba;
        end else if (bst_on && !stop) begin
            beat_on = 1'b1;
            next_bst_col = (bst_col & ~bst_mask) |
                ((bst_col + 8'h01) & bst_mask);
            if (bst_mask != sdr_pkg::PAGE_MASK) begin
                next_bst_left = bst_left - sdr_pkg::LEN_ONE;
                if (bst_left == sdr_pkg::LEN_ONE) begin
                    next_bst_on = 1'b0;
                    end_on = bst_ap;
                end
            end
        end else if (stop) begin
            next_bst_on = 1'b0;
        end
    end

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            next_bank_state[b] = bank_state[b];
            next_wcnt[b] = wcnt[b];
            next_rcnt[b] = rcnt[b];
            next_ap_pend[b] = ap_pend[b];
            pre_go[b] = (bank_state[b] == sdr_pkg::SDR_ACT) &&
                (wcnt[b] == sdr_pkg::CNT_ONE);
            case (bank_state[b])
                sdr_pkg::SDR_IDLE: begin
                    if (op == sdr_pkg::CMD_ACTIVE &&
                        cmd.ba == sdr_pkg::BA_W'(b)) begin
                        next_bank_state[b] = sdr_pkg::SDR_ACT;
                    end
                end
                sdr_pkg::SDR_ACT: begin
                    if (new_acc && cmd.ba == sdr_pkg::BA_W'(b)) begin
                        next_ap_pend[b] = ap_req;
                    end
                    if (pre_go[b]) begin
                        next_wcnt[b] = sdr_pkg::CNT_ZERO;
                        next_bank_state[b] = sdr_pkg::SDR_PRE;
                        next_rcnt[b] = sdr_pkg::TRP_CNT;
                    end else if (wcnt[b] != sdr_pkg::CNT_ZERO) begin
                        next_wcnt[b] = wcnt[b] - sdr_pkg::CNT_ONE;
                    end
                    if ((int_on && int_bank == sdr_pkg::BA_W'(b)) ||
                        (end_on && end_bank == sdr_pkg::BA_W'(b))) begin
                        next_ap_pend[b] = 1'b0;
                        if ((int_on && int_wr) || (end_on && end_wr)) begin
                            next_wcnt[b] = sdr_pkg::TWR_CNT;
                        end else begin
                            next_bank_state[b] = sdr_pkg::SDR_PRE;
                            next_rcnt[b] = sdr_pkg::TRP_CNT;
                        end
                    end
                    if (op == sdr_pkg::CMD_PRECHARGE && !ap_pend[b] &&
                        wcnt[b] == sdr_pkg::CNT_ZERO &&
                        (ap_req || cmd.ba == sdr_pkg::BA_W'(b))) begin
                        next_bank_state[b] = sdr_pkg::SDR_PRE;
                        next_rcnt[b] = sdr_pkg::TRP_CNT;
                    end
                end
                sdr_pkg::SDR_PRE: begin
                    // Row precharge time, then idle
                    if (rcnt[b] <= sdr_pkg::CNT_ONE) begin
                        next_bank_state[b] = sdr_pkg::SDR_IDLE;
                    end else begin
                        next_rcnt[b] = rcnt[b] - sdr_pkg::CNT_ONE;
                    end
                end
                default: begin
                    next_bank_state[b] = sdr_pkg::SDR_IDLE;
                end
            endcase
        end
    end

    // Write words queue up; array port is lent to reads when needed
    assign fifo_in_valid = beat_on && beat_wr;
    assign fifo_in = '{ba: beat_bank, col: beat_col, data: dq_in};
    assign fifo_out_ready = !(beat_on && !beat_wr);

    sdr_fifo #(
        .WIDTH($bits(sdr_pkg::sdr_wword_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(wr_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    always_ff @(posedge core_clk) begin
        if (clk_en && fifo_out_valid && fifo_out_ready) begin
            mem[{fifo_out.ba, fifo_out.col[MEM_COL_W-1:0]}] <= fifo_out.data;
        end
    end

    // Read pipe; output stage loaded at edge CL-1
    always_comb begin
        next_pipe_v[0] = beat_on && !beat_wr;
        next_pipe_d[0] = mem[{beat_bank, beat_col[MEM_COL_W-1:0]}];
        next_pipe_v[1] = pipe_v[0];
        next_pipe_d[1] = pipe_d[0];
        if (cl == sdr_pkg::CL_THREE) begin
            next_dq_oe_n = !pipe_v[1];
            next_dq_out = pipe_d[1];
        end else begin
            next_dq_oe_n = !pipe_v[0];
            next_dq_out = pipe_d[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg <= sdr_pkg::MODE_RESET;
            bst_on <= 1'b0;
            bst_wr <= 1'b0;
            bst_ap <= 1'b0;
            bst_bank <= '0;
            bst_col <= '0;
            bst_mask <= '0;
            bst_left <= '0;
            ap_pend <= '0;
            pipe_v <= '0;
            pipe_d <= '{default: '0};
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            for (int b = 0; b < NB; b++) begin
                bank_state[b] <= sdr_pkg::SDR_IDLE;
                wcnt[b] <= sdr_pkg::CNT_ZERO;
                rcnt[b] <= sdr_pkg::CNT_ZERO;
            end
        end else if (clk_en) begin
            mode_reg <= next_mode_reg;
            bst_on <= next_bst_on;
            bst_wr <= next_bst_wr;
            bst_ap <= next_bst_ap;
            bst_bank <= next_bst_bank;
            bst_col <= next_bst_col;
            bst_mask <= next_bst_mask;
            bst_left <= next_bst_left;
            ap_pend <= next_ap_pend;
            pipe_v <= next_pipe_v;
            pipe_d <= next_pipe_d;
            dq_out <= next_dq_out;
            dq_oe_n <= next_dq_oe_n;
            bank_state <= next_bank_state;
            wcnt <= next_wcnt;
            rcnt <= next_rcnt;
        end
    end

    cs_high_nop_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        cmd.cs_n |=> $stable(mode_reg) && !$rose(bst_on))
        else $error("command with chip select high took effect");

    rd_lat_two_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        rd_acc && cl != sdr_pkg::CL_THREE |-> ##2 !dq_oe_n)
        else $error("read data not out at latency two");

    rd_lat_three_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        rd_acc && cl == sdr_pkg::CL_THREE |-> ##3 !dq_oe_n)
        else $error("read data not out at latency three");

    rd_cuts_write_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        rd_acc && bst_on && bst_wr |=> !(bst_on && bst_wr))
        else $error("write burst kept running after read");

    rd_drops_data_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        rd_acc |-> !fifo_in_valid)
        else $error("data stored on the read edge");

    wr_new_bank_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        wr_acc |-> fifo_in_valid && fifo_in.ba == cmd.ba)
        else $error("new write edge data not for new bank");

    wr_cuts_write_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        wr_acc && bst_on && bst_ap && cmd.ba != bst_bank
        |=> !bst_on || bst_bank == $past(cmd.ba))
        else $error("old write burst not cut by new write");

    rd_recovery_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        int_on && int_wr && rd_acc |-> ##TWR_D (|pre_go))
        else $error("precharge not at write recovery after read");

    wr_recovery_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        int_on && int_wr && wr_acc |-> ##TWR_D (|pre_go))
        else $error("precharge not at write recovery after write");

    pre_to_idle_a: assert property (@(posedge core_clk)
        disable iff (!rst_n || !clk_en)
        pre_go[1] |=> bank_state[1] == sdr_pkg::SDR_PRE
        ##TRP_D bank_state[1] == sdr_pkg::SDR_IDLE)
        else $error("bank one did not go idle after precharge");
endmodule

/* File: verif/sdr_ctl_model.sv */
// Purpose: controller model driving command and write data pins
// Assumes: pins change just after a rising edge of core_clk
// Notes: an idle data line shows the inverse of its last value
`timescale 1ns/1ps
module sdr_ctl_model (
    // Clock
    input wire logic core_clk,
    // Pins to the device
    output sdr_pkg::sdr_cmd_s cmd,
    output logic [15:0] dq_in
);
    initial begin
        cmd = 18'h3C000;
        dq_in = 16'h0000;
    end

    task automatic drv(input logic s, input logic [2:0] op,
                       input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d);
        @(posedge core_clk);
        cmd <= {s, op, b, a};
        dq_in <= d;
    endtask

    // Deselected slot, data released
    task automatic idle();
        drv(1'b1, sdr_pkg::CMD_NO_OPERATION, 2'h0, 12'h000, ~dq_in);
    endtask

    // Start-up, mode load before or after two refreshes
    task automatic init(input logic [11:0] mode, input logic mfirst);
        if (mfirst) begin
            drv(1'b0, sdr_pkg::CMD_LOAD_MODE, 2'h0, mode, ~dq_in);
        end
        repeat (2) drv(1'b0, sdr_pkg::CMD_REFRESH, 2'h0, 12'h000, ~dq_in);
        if (!mfirst) begin
            drv(1'b0, sdr_pkg::CMD_LOAD_MODE, 2'h0, mode, ~dq_in);
        end
    endtask
endmodule

/* File: verif/sdram_write_autoprecharge_interrupt_tb_top.sv */
// Purpose: self-checking bench for the bank interleaving block
// Assumes: CAS latency 2 and burst length 4 after start-up
// Notes: a watch bank of 4 means no bank is watched
`timescale 1ns/1ps
module sdram_write_autoprecharge_interrupt_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    sdr_pkg::sdr_cmd_s cmd;
    logic [15:0] dq_in, dq_out;
    logic dq_oe_n, wr_ready;
    logic [3:0] bank_idle;
    logic [15:0] mem [4][16];
    int fails = 0;
    int tests_run = 0;
    int cl = 2;

    always #50 core_clk = ~core_clk;

    sdr_ctl_model i_ctl (.core_clk(core_clk), .cmd(cmd), .dq_in(dq_in));
    sdr_bank_ctl i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .cmd(cmd), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .wr_ready(wr_ready), .bank_idle(bank_idle));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic test_done();
        $display("Counts fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Idle check of bank wb, m edges after the interrupting edge
    task automatic watch(input int wb, input int m);
        if (wb < 4 && m == sdr_pkg::TWR_CYC) begin
            chk(16'(bank_idle[wb]), 16'h0000);
        end
        if (wb < 4 && m == sdr_pkg::TWR_CYC + sdr_pkg::TRP_CYC) begin
            chk(16'(bank_idle[wb]), 16'h0001);
        end
    endtask

    task automatic wr(input logic [1:0] b, input logic [3:0] c,
                      input int n, input logic ap, input logic [15:0] d,
                      input int wb);
        i_ctl.drv(1'b0, sdr_pkg::CMD_WRITE, b, {1'b0, ap, 6'h00, c}, d);
        mem[b][c] = d;
        for (int i = 1; i < n; i++) begin
            i_ctl.drv(1'b0, sdr_pkg::CMD_NO_OPERATION, b, 12'h000,
                      d + 16'(i));
            mem[b][c + 4'(i)] = d + 16'(i);
            #1;
            watch(wb, i - 1);
        end
    endtask

    task automatic rd(input logic [1:0] b, input logic [3:0] c,
                      input int n, input int wb);
        i_ctl.drv(1'b0, sdr_pkg::CMD_READ, b, {8'h00, c}, 16'hEEEE);
        for (int m = 0; m < cl + n - 1; m++) begin
            i_ctl.idle();
            #1;
            watch(wb, m);
            if (m >= cl - 1) begin
                chk(16'(dq_oe_n), 16'h0000);
                chk(dq_out, mem[b][c + 4'(m - cl + 1)]);
            end
        end
    endtask

    task automatic wait_idle(input logic [3:0] msk);
        int k;
        k = 0;
        #1;
        while ((bank_idle & msk) !== msk) begin
            i_ctl.idle();
            #1;
            k++;
            if (k == 20) begin
                fails++;
                test_done();
            end
        end
    endtask

    task automatic open_bank(input logic [1:0] b);
        wait_idle(4'h1 << b);
        i_ctl.drv(1'b0, sdr_pkg::CMD_ACTIVE, b, 12'h000, ~dq_in);
    endtask

    // Single write through the queue, one idle slot, read back at three
    task automatic fifo_test();
        wr(2'h2, 4'h9, 1, 1'b0, 16'h5A5A, 4);
        i_ctl.idle();
        #1;
        chk(16'(wr_ready), 16'h0001);
        rd(2'h2, 4'h9, 1, 4);
        i_ctl.idle();
        #1;
        chk(16'(dq_oe_n), 16'h0001);
        chk({12'h000, bank_idle}, 16'h000B);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk(16'(dq_oe_n), 16'h0001);
        chk({12'h000, bank_idle}, 16'h000F);
        chk(16'(wr_ready), 16'h0001);
        chk(dq_out, 16'h0000);
        i_ctl.init(12'h022, 1'b1);
        i_ctl.drv(1'b1, sdr_pkg::CMD_LOAD_MODE, 2'h0, 12'h033, 16'h0F0F);
        open_bank(2'h1);
        open_bank(2'h2);
        wr(2'h1, 4'h4, 4, 1'b0, 16'h1100, 4);
        wr(2'h2, 4'h0, 4, 1'b0, 16'h2200, 4);
        // Auto-precharge write on bank 1 cut by a write to bank 2
        wr(2'h1, 4'h4, 2, 1'b1, 16'hA100, 4);
        wr(2'h2, 4'h0, 4, 1'b0, 16'hB200, 1);
        i_ctl.drv(1'b1, sdr_pkg::CMD_WRITE, 2'h2, 12'h000, 16'hDEAD);
        open_bank(2'h1);
        repeat (4) i_ctl.idle();
        rd(2'h1, 4'h4, 4, 4);
        // Same burst cut by a read to bank 2
        wr(2'h1, 4'h4, 2, 1'b1, 16'hC100, 4);
        rd(2'h2, 4'h0, 4, 1);
        open_bank(2'h1);
        repeat (4) i_ctl.idle();
        rd(2'h1, 4'h4, 4, 4);
        i_ctl.drv(1'b0, sdr_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 16'h3C3C);
        wait_idle(4'hF);
        i_ctl.init(12'h030, 1'b0);
        cl = 3;
        open_bank(2'h2);
        rd(2'h2, 4'h1, 1, 4);
        fifo_test();
        test_done();
    end
endmodule
